// >>> uicr_regs.v
`timescale 1ns/100ps
`include "uicr_defs.vh"

module uicr_regs #(
    parameter [7:0] IDENT_BYTE4 = 8'h5A  // Arbitrary identification value.
) (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // AHB-Lite slave.
    input  wire        hsel_i,
    input  wire [11:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire        hready_i,
    input  wire [31:0] hwdata_i,
    output reg  [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    // Interrupt events from the UART datapath, one-cycle pulses, bits 9:4.
    input  wire [5:0]  event_i,
    // Status to the UART.
    output wire [5:0]  raw_status_o,
    output wire [5:0]  masked_status_o,
    output wire        irq_o
);

    // Only whole words are transferred, so the transfer size is not decoded.

    // Byte addresses of the decoded registers as sized constants.
    localparam [11:0]  ADDR_CLEAR  = `UICR_ADDR_INT_CLEAR;
    localparam [11:0]  ADDR_IDENT  = `UICR_ADDR_IDENT_BYTE4;
    localparam [11:0]  ADDR_RAW    = `UICR_ADDR_RAW_STATUS;
    localparam [11:0]  ADDR_MASK   = `UICR_ADDR_MASK;
    localparam [11:0]  ADDR_MASKED = `UICR_ADDR_MASKED_STATUS;

    // Word indices; the two low address bits never take part in decoding.
    localparam [9:0]   IDX_CLEAR   = ADDR_CLEAR[11:2];
    localparam [9:0]   IDX_IDENT   = ADDR_IDENT[11:2];
    localparam [9:0]   IDX_RAW     = ADDR_RAW[11:2];
    localparam [9:0]   IDX_MASK    = ADDR_MASK[11:2];
    localparam [9:0]   IDX_MASKED  = ADDR_MASKED[11:2];

    // Number of interrupt sources handled here.
    localparam integer NSRC        = `UICR_NUM_SRC;

    // Interrupt state.
    reg  [5:0]  raw_reg;
    wire [5:0]  raw_next;
    reg  [5:0]  mask_reg;
    reg  [5:0]  mask_next;
    wire [5:0]  masked_status;

    // Data-phase state of the write taken at the last edge.
    reg         wr_pend_reg;
    reg         wr_pend_next;
    reg  [9:0]  wr_idx_reg;
    reg  [9:0]  wr_idx_next;

    // Address-phase decode.
    wire        take;
    wire        take_wr;
    wire        take_rd;
    wire [9:0]  addr_idx;

    // Data-phase decode.
    wire [5:0]  wr_field;
    wire        clr_hit;
    wire        mask_hit;
    wire [5:0]  clr_bits;

    // Fixed identification word.
    wire [31:0] ident_word;

    // Read path.
    reg  [31:0] rd_next;
    reg  [31:0] hrdata_next;

    // No wait states are ever inserted.
    assign hreadyout_o = 1'b1;

    // Every response is OKAY.
    assign hresp_o     = 1'b0;

    // A transfer is taken when it is selected, the bus is ready and it is neither IDLE nor BUSY.
    assign take     = hsel_i & hready_i & htrans_i[1];
    assign take_wr  = take & hwrite_i;
    assign take_rd  = take & ~hwrite_i;
    assign addr_idx = haddr_i[11:2];

    // Write data follows its address by one cycle, so the write target is held for the data phase.
    always @* begin
        wr_pend_next = take_wr;
        wr_idx_next  = wr_idx_reg;
        if (take_wr) begin
            wr_idx_next = addr_idx;
        end
    end

    // The pending write flag lasts exactly one data phase.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 10'h000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg  <= wr_idx_next;
        end
    end

    // The interrupt field of the write data sits at bits 9:4.
    assign wr_field = hwdata_i[`UICR_BIT_HI:`UICR_BIT_LO];

    assign clr_hit  = wr_pend_reg & (wr_idx_reg == IDX_CLEAR);
    assign clr_bits = clr_hit ? wr_field : 6'h00;

    // The mask register takes the same field on a write to its own address.
    assign mask_hit = wr_pend_reg & (wr_idx_reg == IDX_MASK);

    // Each source is a sticky flag: an event sets it and a clear strobe drops it.
    genvar i;
    generate
        for (i = 0; i < NSRC; i = i + 1) begin : g_src
            assign raw_next[i] = event_i[i] | (raw_reg[i] & ~clr_bits[i]);
        end
    endgenerate

    // A mask write replaces the whole field at the end of its data phase.
    always @* begin
        mask_next = mask_reg;
        if (mask_hit) begin
            mask_next = wr_field;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            raw_reg  <= `UICR_RESET_RAW;
            mask_reg <= `UICR_RESET_MASK;
        end else begin
            raw_reg  <= raw_next;
            mask_reg <= mask_next;
        end
    end

    // Status bit 0 is the receive source and bit 5 the break source.
    // Masked view follows raw.
    assign masked_status   = raw_reg & mask_reg;
    assign raw_status_o    = raw_reg;
    assign masked_status_o = masked_status;
    assign irq_o           = |masked_status;

    assign ident_word = {24'h00_0000, IDENT_BYTE4};

    // Read data is chosen in the address phase and stands in the data phase.
    // Bits 31:10 and 3:0 of every register here except the identification word read as zero.
    always @* begin
        rd_next = 32'h0000_0000;
        case (addr_idx)
            IDX_CLEAR: begin
                rd_next = 32'h0000_0000;
            end
            IDX_IDENT: begin
                // The identification word cannot be written.
                rd_next = ident_word;
            end
            IDX_RAW: begin
                // Raw flags before masking.
                rd_next = {22'h0, raw_reg, 4'h0};
            end
            IDX_MASK: begin
                // Mask as last written.
                rd_next = {22'h0, mask_reg, 4'h0};
            end
            IDX_MASKED: begin
                // Flags that drive the interrupt line.
                rd_next = {22'h0, masked_status, 4'h0};
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // The read data holds until the next read is taken.
    always @* begin
        hrdata_next = hrdata_o;
        if (take_rd) begin
            hrdata_next = rd_next;
        end
    end

    // Reset leaves the read data at zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_o <= `UICR_RESET_ZERO;
        end else begin
            hrdata_o <= hrdata_next;
        end
    end

endmodule

// >>> uicr_defs.vh
`ifndef UICR_DEFS_VH
`define UICR_DEFS_VH

// Byte addresses of the registers (word aligned, address bits 11:2 decoded).
`define UICR_ADDR_INT_CLEAR      12'h044
`define UICR_ADDR_IDENT_BYTE4    12'hFD0
`define UICR_ADDR_RAW_STATUS     12'h03C
`define UICR_ADDR_MASK           12'h038
`define UICR_ADDR_MASKED_STATUS  12'h040

// Interrupt bit positions.
`define UICR_BIT_RX              4
`define UICR_BIT_TX              5
`define UICR_BIT_RX_TIMEOUT      6
`define UICR_BIT_FRAMING         7
`define UICR_BIT_PARITY          8
`define UICR_BIT_BREAK           9
`define UICR_BIT_LO              4
`define UICR_BIT_HI              9
`define UICR_NUM_SRC             6

// Reset values.
`define UICR_RESET_ZERO          32'h0000_0000
`define UICR_RESET_MASK          6'h00
`define UICR_RESET_RAW           6'h00

`endif

// >>> uicr_regs_assertions.sv
`timescale 1ns/100ps
module uicr_chk #(parameter [7:0] IDENT_BYTE4 = 8'h5A) (
    input wire        clk_i, rst_i, hsel_i, hwrite_i, irq_o,
    input wire [1:0]  htrans_i,
    input wire [11:0] haddr_i,
    input wire [31:0] hwdata_i, hrdata_o,
    input wire [5:0]  event_i, raw_status_o, masked_status_o);
    reg        dv, dw;
    reg [11:0] da;
    wire       cw = dv && dw && da == 12'h044;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Tracks the data phase of the transfer taken at the last edge.
    always @(posedge clk_i) begin
        dv <= !rst_i && hsel_i && htrans_i[1];
        dw <= hwrite_i;
        da <= haddr_i;
    end
    ev_set_a: assert property (|event_i |=> (raw_status_o & $past(event_i)) == $past(event_i))
        else $error("event lost");
    clr_bits_a: assert property (cw |=> raw_status_o == ($past(raw_status_o) & ~$past(hwdata_i[9:4])
        | $past(event_i))) else $error("bad clear");
    hold_a: assert property (!cw && !event_i |=> $stable(raw_status_o)) else $error("status moved");
    rst_zero_a: assert property ($fell(rst_i) |-> raw_status_o == 6'h00) else $error("not reset");
    msk_sub_a: assert property ((masked_status_o & ~raw_status_o) == 6'h00) else $error("mask stale");
    irq_or_a: assert property (irq_o == |masked_status_o) else $error("bad irq");
    clr_rd_a: assert property (dv && !dw && da == 12'h044 |-> hrdata_o == 32'h0) else $error("clear read");
    id_rd_a: assert property (dv && !dw && da == 12'hFD0 |-> hrdata_o == {24'h0, IDENT_BYTE4})
        else $error("bad ident");
endmodule
bind uicr_regs uicr_chk #(.IDENT_BYTE4(IDENT_BYTE4)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .hwrite_i(hwrite_i), .irq_o(irq_o), .htrans_i(htrans_i), .haddr_i(haddr_i), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .event_i(event_i), .raw_status_o(raw_status_o), .masked_status_o(masked_status_o));

// >>> uicr_bench.sv
`timescale 1ns/100ps
module uart_irq_clear_and_id_regs_bench;
    reg         clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0;
    reg  [1:0]  htrans_i = 0;
    reg  [11:0] haddr_i = 0;
    reg  [31:0] hwdata_i = 0, rd;
    reg  [5:0]  event_i = 0;
    wire [31:0] hrdata_o;
    wire [5:0]  raw, msk;
    wire        rdy, irq, resp;
    integer     errors = 0, tests_run = 0, k, n;
    uicr_regs #(.IDENT_BYTE4(8'hA7)) dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(rdy), .hwdata_i(hwdata_i),
        .hrdata_o(hrdata_o), .hreadyout_o(rdy), .hresp_o(resp), .event_i(event_i), .raw_status_o(raw),
        .masked_status_o(msk), .irq_o(irq));
    initial forever #12.5 clk_i = ~clk_i;
    task chk(input [63:0] s, e); begin
        tests_run = tests_run + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("[ERR] %0t %h %h", $time, s, e);
        end
    end endtask
    task print_verdict; begin
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end endtask
    task wt; begin
        n = 0;
        do begin @(posedge clk_i); n = n + 1; end while (rdy !== 1'h1 && n < 20);
        if (rdy !== 1'h1) begin errors = errors + 1; print_verdict; end
    end endtask
    // One single transfer; ev is raised during the data phase only.
    task xfer(input w, input [11:0] a, input [31:0] d, input [5:0] ev); begin
        @(posedge clk_i);
        hsel_i <= 1'h1; htrans_i <= 2'h2; hwrite_i <= w; haddr_i <= a;
        wt;
        hsel_i <= 1'h0; htrans_i <= 2'h0; hwdata_i <= d; event_i <= ev;
        wt;
        rd = hrdata_o; event_i <= 6'h0;
    end endtask
    task t_clear; begin
        xfer(1'h1, 12'h044, 32'hF, 6'h0);
        xfer(1'h0, 12'h044, 32'h0, 6'h0);
        chk({raw, rd}, 38'h0);
        xfer(1'h1, 12'h038, 32'h3F0, 6'h0);
        for (k = 0; k < 6; k = k + 1) begin
            @(posedge clk_i);
            event_i <= 6'h3F;
            @(posedge clk_i);
            event_i <= 6'h0;
            xfer(1'h1, 12'h044, 32'h10 << k, 6'h0);
            #1 chk({raw, msk}, {2{6'h3F & ~(6'h1 << k)}});
        end
    end endtask
    task t_race; begin
        xfer(1'h1, 12'h044, 32'h3F0, 6'h1);
        #1 chk({irq, raw}, 7'h41);
    end endtask
    task t_ident; begin
        xfer(1'h1, 12'hFD0, 32'hFFFFFFFF, 6'h0);
        xfer(1'h0, 12'hFD0, 32'h0, 6'h0);
        chk({resp, rd}, {1'h0, 32'hA7});
    end endtask
    task t_view; begin
        xfer(1'h0, 12'h03C, 32'h0, 6'h0);
        chk(rd, 32'h10);
        xfer(1'h0, 12'h040, 32'h0, 6'h0);
        chk(rd, 32'h10);
        xfer(1'h0, 12'h038, 32'h0, 6'h0);
        chk(rd, 32'h3F0);
        xfer(1'h1, 12'h038, 32'h0, 6'h0);
        xfer(1'h0, 12'h040, 32'h0, 6'h0);
        #1 chk({irq, msk, raw, rd}, {13'h001, 32'h0});
    end endtask
    // A second reset in mid-run must drop every pending flag, the masked status and the read data.
    task t_reset; begin
        xfer(1'h1, 12'h038, 32'h3F0, 6'h0);
        @(posedge clk_i);
        event_i <= 6'h3F;
        @(posedge clk_i);
        event_i <= 6'h0;
        rst_i <= 1'h1;
        #1 chk({irq, raw}, 7'h7F);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        #1 chk({irq, msk, raw, hrdata_o}, 45'h0);
    end endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        t_clear;
        t_race;
        t_view;
        t_reset;
        t_ident;
        print_verdict;
    end
endmodule
